// ===== rth_defines.svh
// Constants for the two-wire clock-chip access controller
// Summary of operation
// R1: Device starts an access when SDA falls while SCL is high.
// R2: Device ends the access when SDA rises while SCL is high.
// R3: Only this controller creates start and stop conditions.
// R4: Bytes are eight bits; receiver pulls SDA low on ninth clock.
// R5: Receiver releases SDA at the ninth falling edge unless it transmits next; the controller releases it a quarter after that edge.
// R6: Controller withholds acknowledge after the last read byte.
// R7: First byte is 7-bit address, MSB first, then direction (1 read).
// R8: Device answers only address 0110010.
// R9: Start without stop is a repeated start; address is resent.
// R10: Write's second byte holds a 4-bit pointer and a 4-bit format.
// R11: Pointer sits in bits 7..4, format in bits 3..0.
// R12: Writes always use format 0000.
// R13: Third write byte goes to the pointed register; pointer then increments.
// R14: Pointer wraps from Fh to 0h.
// R15: Every stop loads the pointer with Fh.
// R16: First read method: pointer with format 0, then repeated start, read.
// R17: Format 4h or 5h: device sends data right after the pointer byte.
// R18: Read straight after the address byte starts from pointer Fh.
// R19: Device holds carries from start; applies them within 61 us of stop.
// R20: After 0.5 to 1.0 s from start the device forces the access closed.
// R21: That timer runs from the first start; repeated starts don't restart it.
// R22: After forced release writes get no acknowledge and reads give FFh.
// R23: Controller completes every access within 0.5 s of its start.
// R24: Controller waits 61 us after a stop before the next start.
// R25: Related time registers are moved within one access, no stop between.
// R26: Device ignores a transfer whose address is not its own.
`ifndef RTH_DEFINES_SVH
`define RTH_DEFINES_SVH

`define RTH_DEV_ADDR  7'h32
`define RTH_FMT_WRITE 4'h0
`define RTH_FMT_RD4   4'h4
`define RTH_FMT_RD5   4'h5
`define RTH_CLK_MHZ   100
// Quarter of a 400 kHz bit period, rounded up
`define RTH_QTR_NS    625
`define RTH_QTR_CYC   6'((`RTH_QTR_NS * `RTH_CLK_MHZ + 999) / 1000)
`define RTH_GAP_US    61
`define RTH_GAP_CYC   13'(`RTH_GAP_US * `RTH_CLK_MHZ)
`define RTH_TMO_MS    500
`define RTH_TMO_CYC   26'(`RTH_TMO_MS * 1000 * `RTH_CLK_MHZ)

`endif

// ===== rth_pkg.sv
// Types for the two-wire clock-chip access controller
package rth_pkg;

    typedef enum logic [6:0] {
        RTH_IDLE   = 7'h01,
        RTH_START  = 7'h02,
        RTH_BIT    = 7'h04,
        RTH_LOAD   = 7'h08,
        RTH_RSTART = 7'h10,
        RTH_STOP   = 7'h20,
        RTH_GAP    = 7'h40
    } rth_state_t;

    typedef enum logic [2:0] {
        RTH_ADDR_W = 3'h0,
        RTH_PTR    = 3'h1,
        RTH_ADDR_R = 3'h2,
        RTH_DATA_W = 3'h3,
        RTH_DATA_R = 3'h4
    } rth_stage_t;

    typedef struct packed {
        rth_state_t  st;
        rth_stage_t  stg;
        logic [5:0]  qcnt;
        logic [1:0]  ph;
        logic [3:0]  bitn;
        logic [7:0]  sh;
        logic [3:0]  left;
        logic        rd;
        logic [3:0]  ptr;
        logic [3:0]  fmt;
        logic        scl_oe;
        logic        sda_oe;
        logic        lvl;
        logic [7:0]  rdat;
        logic        rvld;
        logic        wreq;
        logic        done;
        logic        err;
        logic        busy;
        logic [25:0] tmo;
        logic [12:0] gap;
        logic        sda_s1;
        logic        sda_s2;
        logic        scl_s1;
        logic        scl_s2;
    } rth_regs_t;

endpackage

// ===== rth_host.sv
// Two-wire bus controller that reads and writes the clock chip's registers
`timescale 1ns/1ps
`include "rth_defines.svh"

module rth_host
    import rth_pkg::*;
#(
    parameter logic [12:0] GAP_CYC = `RTH_GAP_CYC,
    parameter logic [25:0] TMO_CYC = `RTH_TMO_CYC
) (
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       cmd_valid,
    input  wire logic       cmd_read,
    input  wire logic       cmd_direct,
    input  wire logic [3:0] cmd_ptr,
    input  wire logic [3:0] cmd_fmt,
    input  wire logic [3:0] cmd_len,
    input  wire logic [7:0] wr_data,
    output logic            busy,
    output logic            wr_req,
    output logic [7:0]      rd_data,
    output logic            rd_valid,
    output logic            done,
    output logic            err,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe
);

    rth_regs_t q;
    rth_regs_t d;
    logic      tick;
    logic      tx;
    logic      rx_last;
    logic      abort;

    always_comb begin
        d        = q;
        d.rvld   = 1'b0;
        d.wreq   = 1'b0;
        d.done   = 1'b0;
        d.sda_s1 = sda_i;
        d.sda_s2 = q.sda_s1;
        d.scl_s1 = scl_i;
        d.scl_s2 = q.scl_s1;
        tick     = (q.qcnt == `RTH_QTR_CYC - 6'h01);
        tx       = (q.stg != RTH_DATA_R);
        rx_last  = (q.left == 4'h0);
        // Host gives up before the device's own release can fire
        abort    = q.busy && (q.tmo == TMO_CYC - 26'h1)
                   && (q.st == RTH_BIT || q.st == RTH_LOAD || q.st == RTH_RSTART); // R23
        if (q.st != RTH_IDLE && q.st != RTH_GAP) begin
            d.qcnt = tick ? 6'h00 : q.qcnt + 6'h01;
        end
        // Timer runs from the first start through any repeated start
        if (q.busy && !abort && q.st != RTH_STOP && q.st != RTH_GAP) begin
            d.tmo = q.tmo + 26'h1; // R21
        end
        case (q.st)
            RTH_IDLE: begin
                if (cmd_valid) begin
                    d.busy = 1'b1;
                    d.err  = 1'b0;
                    d.tmo  = 26'h0;
                    d.rd   = cmd_read;
                    d.ptr  = cmd_ptr;
                    d.fmt  = cmd_fmt;
                    d.left = cmd_len;
                    d.ph   = 2'h0;
                    d.qcnt = 6'h00;
                    d.bitn = 4'h0;
                    d.st   = RTH_START;
                    if (cmd_read && cmd_direct) begin
                        d.sh  = {`RTH_DEV_ADDR, 1'b1}; // R18
                        d.stg = RTH_ADDR_R;
                    end else begin
                        d.sh  = {`RTH_DEV_ADDR, 1'b0}; // R7 R8
                        d.stg = RTH_ADDR_W;
                    end
                end
            end
            RTH_START: begin
                if (tick) begin
                    d.ph = q.ph + 2'h1;
                    if (q.ph == 2'h1) begin
                        d.sda_oe = 1'b1; // R1 R3
                    end else if (q.ph == 2'h3) begin
                        d.scl_oe = 1'b1;
                        d.st     = RTH_BIT;
                    end
                end
            end
            RTH_BIT: begin
                if (abort) begin
                    d.err  = 1'b1;
                    d.st   = RTH_STOP;
                    d.ph   = 2'h0;
                    d.qcnt = 6'h00;
                end else if (tick) begin
                    case (q.ph)
                        2'h0: begin
                            d.ph = 2'h1;
                            if (q.bitn == 4'h8) begin
                                // Ack low on received bytes, none after the last one
                                d.sda_oe = !tx && !rx_last; // R4 R6
                            end else begin
                                d.sda_oe = tx && !q.sh[7]; // R4 R5
                            end
                        end
                        2'h1: begin
                            d.scl_oe = 1'b0;
                            d.ph     = 2'h2;
                        end
                        2'h2: begin
                            if (!q.scl_s2) begin
                                // SCL still held low: wait without advancing
                                d.qcnt = q.qcnt;
                            end else begin
                                d.ph = 2'h3;
                                if (q.bitn != 4'h8 && !tx) begin
                                    d.sh = {q.sh[6:0], q.sda_s2};
                                end
                                if (q.bitn == 4'h8 && tx && q.sda_s2) begin
                                    d.err = 1'b1; // R22 R26
                                end
                            end
                        end
                        default: begin
                            d.scl_oe = 1'b1;
                            d.ph     = 2'h0;
                            if (q.bitn != 4'h8) begin
                                d.bitn = q.bitn + 4'h1;
                                if (tx) begin
                                    d.sh = {q.sh[6:0], 1'b1};
                                end
                            end else begin
                                // SDA is let go a quarter later so it never moves with the SCL fall
                                d.bitn   = 4'h0;
                                if (d.err) begin
                                    d.st = RTH_STOP;
                                end else begin
                                    case (q.stg)
                                        RTH_ADDR_W: begin
                                            d.stg = RTH_PTR;
                                            if (q.rd && (q.fmt == `RTH_FMT_RD4
                                                || q.fmt == `RTH_FMT_RD5)) begin
                                                d.sh = {q.ptr, q.fmt}; // R10 R11 R17
                                            end else begin
                                                d.sh = {q.ptr, `RTH_FMT_WRITE}; // R11 R12 R16
                                            end
                                        end
                                        RTH_PTR: begin
                                            if (!q.rd) begin
                                                d.stg  = RTH_DATA_W;
                                                d.st   = RTH_LOAD;
                                                d.wreq = 1'b1; // R13
                                            end else if (q.fmt != `RTH_FMT_RD4
                                                && q.fmt != `RTH_FMT_RD5) begin
                                                d.st = RTH_RSTART; // R16
                                            end else begin
                                                d.stg = RTH_DATA_R; // R17
                                            end
                                        end
                                        RTH_ADDR_R: begin
                                            d.stg = RTH_DATA_R;
                                        end
                                        RTH_DATA_W: begin
                                            // Whole burst in one access keeps registers coherent
                                            d.left = q.left - 4'h1; // R25
                                            if (rx_last) begin
                                                d.st = RTH_STOP;
                                            end else begin
                                                d.st   = RTH_LOAD;
                                                d.wreq = 1'b1;
                                            end
                                        end
                                        default: begin
                                            d.rdat = q.sh;
                                            d.rvld = 1'b1;
                                            d.left = q.left - 4'h1; // R25
                                            if (rx_last) begin
                                                d.st = RTH_STOP; // R6
                                            end
                                        end
                                    endcase
                                end
                            end
                        end
                    endcase
                end
            end
            RTH_LOAD: begin
                d.sh = wr_data;
                d.st = abort ? RTH_STOP : RTH_BIT;
                d.err = q.err | abort;
            end
            RTH_RSTART: begin
                if (abort) begin
                    d.err  = 1'b1;
                    d.st   = RTH_STOP;
                    d.ph   = 2'h0;
                    d.qcnt = 6'h00;
                end else if (tick) begin
                    d.ph = q.ph + 2'h1;
                    case (q.ph)
                        2'h0: d.sda_oe = 1'b0;
                        2'h1: d.scl_oe = 1'b0;
                        2'h2: begin
                            // A stretching target may still hold SCL low
                            if (!q.scl_s2) begin
                                d.ph   = q.ph;
                                d.qcnt = q.qcnt;
                            end else begin
                                d.sda_oe = 1'b1; // R9
                            end
                        end
                        default: begin
                            d.scl_oe = 1'b1;
                            d.sh     = {`RTH_DEV_ADDR, 1'b1}; // R9
                            d.stg    = RTH_ADDR_R;
                            d.st     = RTH_BIT;
                        end
                    endcase
                end
            end
            RTH_STOP: begin
                if (tick) begin
                    d.ph = q.ph + 2'h1;
                    case (q.ph)
                        2'h0: d.scl_oe = 1'b1;
                        2'h1: d.sda_oe = 1'b1;
                        2'h2: d.scl_oe = 1'b0;
                        default: begin
                            if (!q.scl_s2) begin
                                d.ph   = q.ph;
                                d.qcnt = q.qcnt;
                            end else begin
                                d.sda_oe = 1'b0; // R3
                                d.gap    = 13'h0;
                                d.st     = RTH_GAP;
                            end
                        end
                    endcase
                end
            end
            RTH_GAP: begin
                // Device applies held carries here, so no new start yet
                d.gap = q.gap + 13'h1; // R24 R15
                if (q.gap == GAP_CYC - 13'h1) begin
                    d.busy = 1'b0;
                    d.done = 1'b1;
                    d.st   = RTH_IDLE;
                end
            end
            default: begin
                d.st = RTH_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            q        <= '0;
            q.st     <= RTH_IDLE;
            q.stg    <= RTH_ADDR_W;
            q.sda_s1 <= 1'b1;
            q.sda_s2 <= 1'b1;
            q.scl_s1 <= 1'b1;
            q.scl_s2 <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign busy     = q.busy;
    assign wr_req   = q.wreq;
    assign rd_data  = q.rdat;
    assign rd_valid = q.rvld;
    assign done     = q.done;
    assign err      = q.err;
    assign scl_o    = q.lvl;
    assign scl_oe   = q.scl_oe;
    assign sda_o    = q.lvl;
    assign sda_oe   = q.sda_oe;

endmodule // rth_host

// ===== rth_host_props.sv
// Port-level checks for the two-wire clock-chip access controller
`timescale 1ns/1ps
module rth_host_props
#(
    parameter logic [12:0] GAP_CYC = 13'h0014,
    parameter logic [25:0] TMO_CYC = 26'h0000BB8
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic busy,
    input wire logic done,
    input wire logic err,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic scl_i,
    input wire logic sda_i
);
    logic        scl_p_q;
    logic        sda_p_q;
    logic [13:0] quiet_q;
    logic [26:0] acc_q;
    wire         start_ev = scl_i && scl_p_q && sda_p_q && !sda_i;
    wire         stop_ev  = scl_i && scl_p_q && !sda_p_q && sda_i;
    // Counters for spacing and length; quiet_q saturates, acc_q clears when busy is low but has no cap while busy
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_p_q <= 1'h1;
            sda_p_q <= 1'h1;
            quiet_q <= 14'h3FFF;
            acc_q   <= 27'h0000000;
        end else begin
            scl_p_q <= scl_i;
            sda_p_q <= sda_i;
            quiet_q <= stop_ev ? 14'h0000 : (&quiet_q ? quiet_q : quiet_q + 14'h0001);
            acc_q   <= busy ? acc_q + 27'h0000001 : 27'h0000000;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_idle_released: assert property (!busy |-> !scl_oe && !sda_oe)
        else $error("bus lines pulled while idle");
    a_start_by_host: assert property (start_ev |-> sda_oe)
        else $error("start not made by controller");
    a_stop_by_host: assert property (stop_ev |-> !sda_oe && $past(sda_oe))
        else $error("stop not made by controller");
    a_gap_kept: assert property (start_ev |-> quiet_q >= {1'h0, GAP_CYC})
        else $error("start too soon after stop");
    a_access_bounded: assert property
        (busy |-> acc_q <= {1'h0, TMO_CYC} + {14'h0, GAP_CYC} + 27'h00003E8)
        else $error("access lasted too long");
    a_scl_high_min: assert property ($rose(scl_i) |-> scl_i [*8])
        else $error("clock high phase too short");
    a_cmd_taken: assert property (cmd_valid && !busy |=> busy)
        else $error("command not taken");
    a_done_closes: assert property (done |-> !busy && $past(busy))
        else $error("done without closing access");
    a_err_clears: assert property (cmd_valid && !busy |=> !err)
        else $error("error flag not cleared by command");
    cover property (stop_ev ##[1:40] done);
    cover property ($rose(err));
    cover property (start_ev && quiet_q == 14'h3FFF);
endmodule // rth_host_props

// ===== rth_dev_model.sv
// Behavioural clock-chip target on the two-wire bus
`timescale 1ns/1ps
module rth_dev_model
#(
    parameter time TMO_NS = 1000000000
) (
    input  wire logic        scl,
    input  wire logic        sda,
    input  wire logic [11:0] slow_ns,
    output logic             pull_sda,
    output logic             hold_scl
);
    logic [7:0] mem [16];
    logic [7:0] sh;
    logic [7:0] tx_byte;
    logic [3:0] ptr;
    logic       active, held, freed, rd, tx, go_tx, hack;
    int         bitc, nb;
    time        t0;
    initial begin
        for (int i = 0; i < 16; i++) mem[i] = {4'hA, 4'(i)};
        ptr = 4'hF;
        {active, held, freed, rd, tx, go_tx, pull_sda, hold_scl} = 8'h00;
    end
    always @(negedge sda) if (scl) begin
        if (!held) t0 = $time;
        held = 1'h1;
        active = 1'h1;
        // The SCL fall that follows the start is not a data clock
        bitc = -1;
        nb = 0;
        {tx, go_tx} = 2'h0;
    end
    always @(posedge sda) if (scl) begin
        {active, held, freed} = 3'h0;
        ptr = 4'hF;
    end
    always @(posedge scl) begin
        if (bitc < 8) sh = {sh[6:0], sda};
        else hack = !sda;
    end
    always @(negedge scl) if (active) begin
        if ($time - t0 >= TMO_NS) freed = 1'h1;
        bitc = bitc + 1;
        if (bitc < 8) begin
            pull_sda = tx && !tx_byte[7 - bitc];
        end else if (bitc == 8) begin
            pull_sda = 1'h0;
            if (!tx && nb == 0) begin
                active = (sh[7:1] == 7'h32);
                rd = sh[0];
                pull_sda = active;
            end else if (!tx) begin
                if (nb == 1 && !rd) begin
                    ptr = sh[7:4];
                    go_tx = (sh[3:0] == 4'h4) || (sh[3:0] == 4'h5);
                end else if (!freed) begin
                    mem[ptr] = sh;
                    ptr = ptr + 4'h1;
                end
                pull_sda = !freed;
            end
        end else begin
            bitc = 0;
            nb = nb + 1;
            pull_sda = 1'h0;
            // Optional stretch models a slow target; the controller must wait for it
            if (slow_ns != 12'h000) begin
                hold_scl <= 1'h1;
                hold_scl <= #(slow_ns) 1'h0;
            end
            if ((rd || go_tx) && !(tx && !hack)) begin
                tx = 1'h1;
                tx_byte = freed ? 8'hFF : mem[ptr];
                ptr = ptr + 4'h1;
                pull_sda = !tx_byte[7];
            end else tx = 1'h0;
        end
    end
endmodule // rth_dev_model

// ===== tb.sv
// Self-checking bench for the two-wire clock-chip access controller
`timescale 1ns/1ps
module tb;
    logic        clk, sys_rst, cmd_valid, cmd_read, cmd_direct;
    logic [3:0]  cmd_ptr, cmd_fmt, cmd_len;
    logic [7:0]  wr_data, rd_data;
    logic        busy, wr_req, rd_valid, done, err, scl_oe, sda_oe, pull_sda, hold_scl;
    logic [11:0] slow_ns;
    logic [31:0] seed;
    logic [7:0]  mem_e [16];
    int          bad_count, compares;
    wire         scl_w = !(scl_oe || hold_scl);
    wire         sda_w = !(sda_oe || pull_sda);
    rth_host #(.GAP_CYC(13'h0014), .TMO_CYC(26'h0003E80)) DUT (.clk(clk), .sys_rst(sys_rst),
        .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_direct(cmd_direct), .cmd_ptr(cmd_ptr),
        .cmd_fmt(cmd_fmt), .cmd_len(cmd_len), .wr_data(wr_data), .busy(busy), .wr_req(wr_req),
        .rd_data(rd_data), .rd_valid(rd_valid), .done(done), .err(err), .scl_i(scl_w),
        .scl_o(), .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe));
    // Target release falls between the longest clean access and the host's own limit
    rth_dev_model #(.TMO_NS(132000)) u_dev (.scl(scl_w), .sda(sda_w), .slow_ns(slow_ns),
        .pull_sda(pull_sda),
        .hold_scl(hold_scl));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic chk8(input logic [7:0] got, input logic [7:0] want);
        compares++;
        if (got !== want) begin
            bad_count++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task automatic chk1(input logic got, input logic want);
        compares++;
        if (got !== want) begin
            bad_count++;
            $display("BAD t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    task automatic stop_test;
        $display("bad_count=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // One access; the expected pointer walk is kept here, apart from the target model
    task automatic run(input logic rd, dir, input logic [3:0] p, f, n, input logic e);
        logic [3:0] a;
        int         k, w, t;
        a = (rd && dir) ? 4'hF : p;
        k = 0;
        w = 0;
        {cmd_read, cmd_direct, cmd_ptr, cmd_fmt, cmd_len, cmd_valid} = {rd, dir, p, f, n, 1'h1};
        @(posedge clk);
        #1 cmd_valid = 1'h0;
        for (t = 0; t < 60000 && done !== 1'h1; t++) begin
            @(posedge clk);
            #1;
            if (wr_req === 1'h1) begin
                seed = lfsr(seed);
                wr_data = seed[7:0];
                mem_e[a] = seed[7:0];
                a = a + 4'h1;
                w++;
            end
            if (rd_valid === 1'h1) begin
                chk8(rd_data, mem_e[a]);
                a = a + 4'h1;
                k++;
            end
        end
        if (t >= 60000) begin
            bad_count++;
            stop_test;
        end
        chk1(err, e);
        if (e === 1'h0) chk8(8'(k + w), {4'h0, n} + 8'h01);
    endtask
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    initial begin
        logic [3:0] p;
        {sys_rst, cmd_valid, cmd_read, cmd_direct, cmd_ptr, cmd_fmt, cmd_len} = 16'h8000;
        wr_data = 8'h00;
        slow_ns = 12'h000;
        bad_count = 0;
        compares = 0;
        seed = 32'h0AFB8BC0;
        for (int i = 0; i < 16; i++) mem_e[i] = {4'hA, 4'(i)};
        repeat (8) @(posedge clk);
        #1 sys_rst = 1'h0;
        run(1'h0, 1'h0, 4'hE, 4'h0, 4'h2, 1'h0);
        slow_ns = 12'h7D3;
        run(1'h1, 1'h0, 4'hF, 4'h0, 4'h1, 1'h0);
        slow_ns = 12'h000;
        run(1'h1, 1'h1, 4'h3, 4'h0, 4'h1, 1'h0);
        seed = lfsr(seed);
        p = seed[11:8];
        run(1'h0, 1'h0, p, 4'h0, 4'h0, 1'h0);
        run(1'h1, 1'h0, p, 4'h5, 4'h0, 1'h0);
        run(1'h1, 1'h0, 4'hE, 4'h4, 4'h0, 1'h0);
        run(1'h1, 1'h1, 4'h0, 4'h0, 4'hF, 1'h1);
        run(1'h1, 1'h1, 4'h0, 4'h0, 4'h0, 1'h0);
        stop_test;
    end
endmodule // tb
bind rth_host rth_host_props #(.GAP_CYC(GAP_CYC), .TMO_CYC(TMO_CYC)) u_props (.clk(clk),
    .sys_rst(sys_rst), .cmd_valid(cmd_valid), .busy(busy), .done(done), .err(err),
    .scl_oe(scl_oe), .sda_oe(sda_oe), .scl_i(scl_i), .sda_i(sda_i));
